// ==== rpsc_pkg.sv ====
package rpsc_pkg;

    // Word offsets on the register bus (byte addresses)
    localparam logic [7:0] RPSC_OFS_CONFIGURED = 8'h60;  // Configured register
    localparam logic [7:0] RPSC_OFS_PORT       = 8'h64;  // Root link status/control
    localparam logic [7:0] RPSC_OFS_IRQ_STS    = 8'h70;  // Sticky event status
    localparam logic [7:0] RPSC_OFS_IRQ_MSK    = 8'h74;  // Event mask

    // Field positions in the root link status/control word and the configured register
    localparam int RPSC_BIT_CCS    = 0;   // Connect present
    localparam int RPSC_BIT_CSC    = 1;   // Connect change
    localparam int RPSC_BIT_PED    = 2;   // Port enabled
    localparam int RPSC_BIT_FPR    = 6;   // Resume signalling
    localparam int RPSC_BIT_SUSPENDED_BIT   = 7;   // Suspended
    localparam int RPSC_BIT_PR     = 8;   // Bus reset active
    localparam int RPSC_BIT_LS_LO  = 10;  // Line state, DM; DP sits one above
    localparam int RPSC_BIT_PP     = 12;  // Power switch
    localparam int RPSC_BIT_PO     = 13;  // Owner handoff
    localparam int RPSC_BIT_PIC_LO = 14;  // Indicator control, two bits
    localparam int RPSC_BIT_PTC_LO = 16;  // Test select, four bits
    localparam int RPSC_BIT_CF     = 0;   // Configured bit

    // Event bits of the status and mask registers
    localparam int RPSC_IRQ_CONN   = 0;   // Connect change event
    localparam int RPSC_IRQ_RESUME = 1;   // Remote resume event

    // Synchroniser lanes for pin inputs
    localparam int RPSC_SYN_DP  = 0;      // D+ level
    localparam int RPSC_SYN_DM  = 1;      // D- level
    localparam int RPSC_SYN_ATT = 2;      // Attach detect
    localparam int RPSC_SYN_RSM = 3;      // Resume K detect

    // Reset value of the port word as documented
    localparam logic [31:0] RPSC_PORT_RST = 32'h0000_2000;

    // Port control outputs toward the transceiver
    typedef struct packed {
        logic       power_on;     // Port power switch on
        logic       enabled;      // Port enabled
        logic       bus_reset;    // Drive bus reset
        logic       suspend;      // Port suspended
        logic       resume_drive; // Drive resume K
        logic       owner;        // Owner handoff
        logic       test_mode;    // Any test mode active
        logic [1:0] indicator;    // Indicator control
        logic [3:0] test_sel;     // Selected test mode
    } rpsc_port_ctl_t;

    // Whole state of the block
    typedef struct packed {
        logic [3:0]  sync1;    // First sync stage
        logic [3:0]  sync2;    // Second sync stage
        logic        ccs;      // Connect present
        logic        csc;      // Connect change
        logic        enabled_flag;      // Enabled
        logic        pr;       // Bus reset
        logic        suspended_bit;     // Suspended
        logic        resume_signal_bit;      // Resume
        logic        pp;       // Power switch
        logic        po;       // Owner
        logic [1:0]  indicator_ctl_field;      // Indicator
        logic [3:0]  test_select_field;      // Test select
        logic        cf;       // Configured
        logic [1:0]  irq_sts;  // Sticky events
        logic [1:0]  irq_msk;  // Event mask
        logic        ack;      // Bus ack
        logic [31:0] rdat;     // Read data
    } rpsc_state_t;

    localparam rpsc_state_t RPSC_STATE_RST = '{
        sync1: 4'h0, sync2: 4'h0, ccs: 1'b0, csc: 1'b0, enabled_flag: 1'b0, pr: 1'b0,
        suspended_bit: 1'b0, resume_signal_bit: 1'b0, pp: 1'b0, po: RPSC_PORT_RST[RPSC_BIT_PO],
        indicator_ctl_field: 2'h0, test_select_field: 4'h0, cf: 1'b0, irq_sts: 2'h0, irq_msk: 2'h0,
        ack: 1'b0, rdat: 32'h0000_0000};

endpackage : rpsc_pkg

// ==== rpsc_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module rpsc_port
    import rpsc_pkg::*;
(
    input  wire logic        clk_sys,            // 250 MHz system clock
    input  wire logic        resetn,             // Async reset, power-up
    input  wire logic        hc_reset_i,         // Controller reset, same clock
    input  wire logic        wb_cyc_i,           // Wishbone cycle
    input  wire logic        wb_stb_i,           // Wishbone strobe
    input  wire logic        wb_we_i,            // Wishbone write
    input  wire logic [7:2]  wb_adr_i,           // Wishbone word address
    input  wire logic [3:0]  wb_sel_i,           // Wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,           // Wishbone write data
    output logic      [31:0] wb_dat_o,           // Wishbone read data
    output logic             wb_ack_o,           // Wishbone ack
    input  wire logic        cap_indicator_i,    // Indicator capability strap
    input  wire logic        cap_power_switch_i, // Power switching capability
    input  wire logic        line_dp_i,          // D+ level, async
    input  wire logic        line_dm_i,          // D- level, async
    input  wire logic        attach_i,           // Device attached, async
    input  wire logic        resume_k_i,         // Resume K seen, async
    output rpsc_port_ctl_t   port_ctl_o,         // Port controls
    output logic             irq_o               // Level interrupt
);

    rpsc_state_t s_q;        // Registered state
    rpsc_state_t s_d;        // Next state
    logic        pp_eff;     // Power as seen by software
    logic        att;        // Synced attach
    logic        rsm;        // Synced resume K
    logic        req;        // Bus request present
    logic        wr;         // Write takes effect now
    logic        wr_port;    // Write to port word
    logic [31:0] port_word;  // Port word as read
    logic [31:0] wval;       // Merged port write value
    logic [31:0] rd_word;    // Decoded read value

    // Merge write data into an old word by byte lane
    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : byte_merge

    // Port word as software sees it; reserved bits zero
    function automatic logic [31:0] port_view(input rpsc_state_t s,
                                              input logic        pw);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[RPSC_BIT_PTC_LO +: 4] = s.test_select_field;
        w[RPSC_BIT_PO]          = s.po;
        w[RPSC_BIT_PP]          = pw;
        w[RPSC_BIT_LS_LO + 1]   = s.sync2[RPSC_SYN_DP];
        w[RPSC_BIT_LS_LO]       = s.sync2[RPSC_SYN_DM];
        w[RPSC_BIT_FPR]         = s.resume_signal_bit;
        w[RPSC_BIT_PED]         = s.enabled_flag;
        // Powered-down port hides these fields
        if (pw) begin
            w[RPSC_BIT_PIC_LO +: 2] = s.indicator_ctl_field;
            w[RPSC_BIT_PR]          = s.pr;
            w[RPSC_BIT_SUSPENDED_BIT]        = s.suspended_bit;
            w[RPSC_BIT_CSC]         = s.csc;
            w[RPSC_BIT_CCS]         = s.ccs;
        end
        return w;
    endfunction : port_view

    // Without a switch the port is always powered
    assign pp_eff    = cap_power_switch_i ? s_q.pp : 1'b1;
    assign att       = s_q.sync2[RPSC_SYN_ATT];
    assign rsm       = s_q.sync2[RPSC_SYN_RSM];
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr        = req & wb_we_i & s_q.ack;
    assign wr_port   = wr & (wb_adr_i == RPSC_OFS_PORT[7:2]);
    assign port_word = port_view(s_q, pp_eff);
    assign wval      = byte_merge(port_word, wb_dat_i, wb_sel_i);

    // Read decode; unmapped words read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            RPSC_OFS_PORT[7:2]:       rd_word = port_word;
            RPSC_OFS_CONFIGURED[7:2]: rd_word[RPSC_BIT_CF] = s_q.cf;
            RPSC_OFS_IRQ_STS[7:2]:    rd_word[1:0] = s_q.irq_sts;
            RPSC_OFS_IRQ_MSK[7:2]:    rd_word[1:0] = s_q.irq_msk;
            default:                  rd_word = 32'h0000_0000;
        endcase
    end

    // Next-state logic; hardware events come last so a set wins
    always_comb begin
        s_d = s_q;
        // Two-flop synchronisers for pin inputs
        s_d.sync1 = {resume_k_i, attach_i, line_dm_i, line_dp_i};
        s_d.sync2 = s_q.sync1;
        // One wait state; ack falls the cycle after it rose
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack) begin
            s_d.rdat = rd_word;
        end

        // Port word writes
        if (wr_port) begin
            if (cap_power_switch_i) begin
                s_d.pp = wval[RPSC_BIT_PP];
            end
            // Unpowered port takes no state change
            if (pp_eff) begin
                s_d.test_select_field = wval[RPSC_BIT_PTC_LO +: 4];
                if (cap_indicator_i) begin
                    s_d.indicator_ctl_field = wval[RPSC_BIT_PIC_LO +: 2];
                end
                if (s_q.cf) begin
                    s_d.po = wval[RPSC_BIT_PO];
                end
                s_d.pr = wval[RPSC_BIT_PR];
                // Entering bus reset disables the port
                if (wval[RPSC_BIT_PR]) begin
                    s_d.enabled_flag  = 1'b0;
                    s_d.suspended_bit = 1'b0;
                end else if (s_q.pr & s_q.ccs) begin
                    // Reset completion enables an attached port
                    s_d.enabled_flag = 1'b1;
                end else if (!wval[RPSC_BIT_PED]) begin
                    // Software may only disable
                    s_d.enabled_flag = 1'b0;
                end
                // Suspend only an enabled port
                if (wval[RPSC_BIT_SUSPENDED_BIT] & s_q.enabled_flag) begin
                    s_d.suspended_bit = 1'b1;
                end
                s_d.resume_signal_bit = wval[RPSC_BIT_FPR];
                // Ending resume leaves suspend
                if (s_q.resume_signal_bit & ~wval[RPSC_BIT_FPR]) begin
                    s_d.suspended_bit = 1'b0;
                end
                if (wb_dat_i[RPSC_BIT_CSC] & wb_sel_i[0]) begin
                    s_d.csc = 1'b0;
                end
            end
            // Power removed drops the live port state
            if (cap_power_switch_i & ~wval[RPSC_BIT_PP]) begin
                s_d.enabled_flag  = 1'b0;
                s_d.pr   = 1'b0;
                s_d.suspended_bit = 1'b0;
                s_d.resume_signal_bit  = 1'b0;
            end
        end

        // Configured register write
        if (wr & (wb_adr_i == RPSC_OFS_CONFIGURED[7:2]) & wb_sel_i[0]) begin
            s_d.cf = wb_dat_i[RPSC_BIT_CF];
        end
        // Event status clears by writing one
        if (wr & (wb_adr_i == RPSC_OFS_IRQ_STS[7:2]) & wb_sel_i[0]) begin
            s_d.irq_sts = s_q.irq_sts & ~wb_dat_i[1:0];
        end
        if (wr & (wb_adr_i == RPSC_OFS_IRQ_MSK[7:2]) & wb_sel_i[0]) begin
            s_d.irq_msk = wb_dat_i[1:0];
        end

        // Owner handoff follows the configured bit
        if (!s_d.cf) begin
            s_d.po = 1'b1;
        end else if (!s_q.cf) begin
            s_d.po = 1'b0;
        end

        // Attach is only seen on a powered port
        s_d.ccs = att & pp_eff;
        if (s_d.ccs != s_q.ccs) begin
            s_d.csc                      = 1'b1;
            s_d.irq_sts[RPSC_IRQ_CONN]   = 1'b1;
            if (!s_d.ccs) begin
                // Disconnect disables the port
                s_d.enabled_flag  = 1'b0;
                s_d.suspended_bit = 1'b0;
            end
        end
        // Remote wakeup while suspended starts resume
        if (rsm & s_q.suspended_bit & ~s_q.resume_signal_bit) begin
            s_d.resume_signal_bit                      = 1'b1;
            s_d.irq_sts[RPSC_IRQ_RESUME] = 1'b1;
        end

        // Controller reset; bus handshake is kept alive
        if (hc_reset_i) begin
            s_d       = RPSC_STATE_RST;
            s_d.sync1 = s_q.sync1;
            s_d.sync2 = s_q.sync2;
            s_d.ack   = req & ~s_q.ack;
            s_d.rdat  = (req & ~s_q.ack) ? rd_word : s_q.rdat;
        end
    end

    // State register; power-up reset only otherwise
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q <= RPSC_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign irq_o    = |(s_q.irq_sts & s_q.irq_msk);

    // Port controls toward the transceiver
    always_comb begin
        port_ctl_o              = '0;
        port_ctl_o.power_on     = pp_eff;
        port_ctl_o.enabled      = s_q.enabled_flag;
        port_ctl_o.bus_reset    = s_q.pr;
        port_ctl_o.suspend      = s_q.suspended_bit;
        port_ctl_o.resume_drive = s_q.resume_signal_bit;
        port_ctl_o.owner        = s_q.po;
        port_ctl_o.test_mode    = (s_q.test_select_field != 4'h0);
        port_ctl_o.test_sel     = s_q.test_select_field;
        port_ctl_o.indicator    = s_q.indicator_ctl_field;
    end

    // Checks on the block's own behaviour

    property p_connect_change;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.ccs != $past(s_q.ccs)) && !$past(hc_reset_i) |-> s_q.csc;
    endproperty
    a_connect_change: assert property (p_connect_change)
        else $error("connect change flag missed a presence change");

    property p_present;
        @(posedge clk_sys) disable iff (!resetn)
        (att && pp_eff && !hc_reset_i) |=> s_q.ccs;
    endproperty
    a_present: assert property (p_present)
        else $error("attached device not reported present");

    property p_hc_reset;
        @(posedge clk_sys) disable iff (!resetn)
        hc_reset_i |=> !s_q.enabled_flag && !s_q.ccs && s_q.po && (s_q.test_select_field == 4'h0);
    endproperty
    a_hc_reset: assert property (p_hc_reset)
        else $error("controller reset left port not in initial state");

    property p_test_write;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_port && pp_eff && wb_sel_i[2] && !hc_reset_i)
        |=> (s_q.test_select_field == $past(wb_dat_i[19:16])) && (port_ctl_o.test_mode == (s_q.test_select_field != 4'h0));
    endproperty
    a_test_write: assert property (p_test_write)
        else $error("test select not taken from write");

    property p_ind_ignore;
        @(posedge clk_sys) disable iff (!resetn)
        (!cap_indicator_i && !hc_reset_i) |=> $stable(s_q.indicator_ctl_field);
    endproperty
    a_ind_ignore: assert property (p_ind_ignore)
        else $error("indicator field changed without capability");

    property p_owner;
        @(posedge clk_sys) disable iff (!resetn)
        (!s_q.cf |-> s_q.po) and ($rose(s_q.cf) |-> !s_q.po);
    endproperty
    a_owner: assert property (p_owner)
        else $error("owner handoff does not follow configured bit");

    property p_unpowered_ignore;
        @(posedge clk_sys) disable iff (!resetn)
        (cap_power_switch_i && !s_q.pp && wr_port && !hc_reset_i)
        |=> $stable(s_q.test_select_field) && $stable(s_q.pr) && $stable(s_q.indicator_ctl_field);
    endproperty
    a_unpowered_ignore: assert property (p_unpowered_ignore)
        else $error("unpowered port accepted a state change");

    property p_unpowered_read;
        @(posedge clk_sys) disable iff (!resetn)
        (req && !s_q.ack && wb_adr_i == RPSC_OFS_PORT[7:2] && !pp_eff)
        |=> wb_ack_o && (wb_dat_o[15:14] == 2'h0) && (wb_dat_o[8:7] == 2'h0)
            && (wb_dat_o[1:0] == 2'h0) && !wb_dat_o[RPSC_BIT_PP];
    endproperty
    a_unpowered_read: assert property (p_unpowered_read)
        else $error("unpowered port read shows gated fields");

    property p_fixed_power;
        @(posedge clk_sys) disable iff (!resetn)
        (req && !s_q.ack && wb_adr_i == RPSC_OFS_PORT[7:2] && !cap_power_switch_i)
        |=> wb_dat_o[RPSC_BIT_PP];
    endproperty
    a_fixed_power: assert property (p_fixed_power)
        else $error("power bit not fixed high without switching");

    property p_line_state;
        @(posedge clk_sys) disable iff (!resetn)
        (req && !s_q.ack && wb_adr_i == RPSC_OFS_PORT[7:2])
        |=> wb_dat_o[11:10] == $past({s_q.sync2[RPSC_SYN_DP], s_q.sync2[RPSC_SYN_DM]})
            && wb_dat_o[8] == ($past(s_q.pr) && $past(pp_eff));
    endproperty
    a_line_state: assert property (p_line_state)
        else $error("line state or reset bit read wrong");

    property p_resume;
        @(posedge clk_sys) disable iff (!resetn)
        (rsm && s_q.suspended_bit && !s_q.resume_signal_bit && !hc_reset_i) |=> s_q.resume_signal_bit ##1 irq_o || !s_q.irq_msk[1];
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume detect not reported");

    property p_csc_clear;
        @(posedge clk_sys) disable iff (!resetn)
        (wr_port && pp_eff && wb_sel_i[0] && wb_dat_i[RPSC_BIT_CSC] && !hc_reset_i
         && (att && pp_eff) == s_q.ccs) |=> !s_q.csc;
    endproperty
    a_csc_clear: assert property (p_csc_clear)
        else $error("write one did not clear connect change");

    // A port only enters suspend while it is enabled
    property p_suspend_enabled;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(s_q.suspended_bit) |-> $past(s_q.enabled_flag);
    endproperty
    a_suspend_enabled: assert property (p_suspend_enabled)
        else $error("port suspended while disabled");

    // Enable only comes from the end of a bus reset
    property p_enable_source;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(s_q.enabled_flag) |-> $past(s_q.pr) && !s_q.pr;
    endproperty
    a_enable_source: assert property (p_enable_source)
        else $error("port enabled without finishing bus reset");

    // Presence change raises its event even against a clearing write
    property p_conn_event;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.ccs != $past(s_q.ccs)) && !$past(hc_reset_i) |-> s_q.irq_sts[RPSC_IRQ_CONN];
    endproperty
    a_conn_event: assert property (p_conn_event)
        else $error("connect event lost against a clear");

endmodule : rpsc_port

`default_nettype wire

// ==== rpsc_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Full-speed peripheral hanging on the downstream port
module rpsc_dev_model (
    input  wire logic attach_cmd, // Plug the device in
    input  wire logic resume_cmd, // Ask for remote resume
    output logic      dp,         // D+ level
    output logic      dm,         // D- level
    output logic      attached,   // Attach detect
    output logic      resume_k    // Resume K seen
);
    // Unplugged lines fall to the host pull-downs, never hold the last level
    always_comb begin
        attached = attach_cmd;
        resume_k = attach_cmd & resume_cmd;
        dp       = attach_cmd & ~resume_cmd; // J while idle, K on resume
        dm       = attach_cmd & resume_cmd;
    end
endmodule : rpsc_dev_model

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rpsc_pkg::*;
    logic           clk_sys = 1'b0; // System clock
    logic           resetn  = 1'b0; // Power-up reset
    logic           hc_rst  = 1'b0; // Controller reset
    logic           cyc     = 1'b0; // Bus cycle
    logic           stb     = 1'b0; // Bus strobe
    logic           we      = 1'b0; // Bus write
    logic [7:2]     adr     = 6'h00; // Word address
    logic [31:0]    wdat    = 32'h0000_0000; // Write data
    logic [3:0]     sel     = 4'hF;         // Byte lanes on the bus
    logic [3:0]     lanes   = 4'hF;         // Lanes the next request uses
    logic [31:0]    rdat;           // Read data
    logic           ack;            // Bus ack
    logic           ind     = 1'b0; // Indicator capability
    logic           psw     = 1'b1; // Power switch capability
    logic           att     = 1'b0; // Plug command
    logic           res     = 1'b0; // Resume command
    logic           dp, dm, attd, rk; // Pins from the peripheral
    rpsc_port_ctl_t ctl;            // Port controls
    logic           irq;            // Interrupt line
    int             errors  = 0;    // Mismatches
    int             checks  = 0;    // Comparisons

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    rpsc_port i_rpsc_port (.clk_sys(clk_sys), .resetn(resetn), .hc_reset_i(hc_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cap_indicator_i(ind),
        .cap_power_switch_i(psw), .line_dp_i(dp), .line_dm_i(dm), .attach_i(attd),
        .resume_k_i(rk), .port_ctl_o(ctl), .irq_o(irq));

    rpsc_dev_model i_rpsc_dev_model (.attach_cmd(att), .resume_cmd(res), .dp(dp), .dm(dm),
        .attached(attd), .resume_k(rk));

    // Expected port word; an unpowered port hides the listed fields
    function automatic logic [31:0] pw(input logic [3:0] tc, input logic [1:0] ic,
        input logic po, pp, lp, lm, pr, su, fr, en, cc, cp);
        if (!pp) {ic, pr, su, cc, cp} = 6'h00;
        return {12'h000, tc, ic, po, pp, lp, lm, 1'b0, pr, su, fr, 3'h0, en, cc, cp};
    endfunction : pw

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic cycle; request held until ack is sampled
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a[7:2];
        wdat <= d;
        sel  <= lanes;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 16) chk("bus ack", 32'h0, 32'h1);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(nm, q, exp);
    endtask : rc

    // Pins reach the word three edges after they move
    task automatic pins();
        repeat (4) @(posedge clk_sys);
    endtask : pins

    task automatic hc_pulse();
        hc_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        hc_rst <= 1'b0;
    endtask : hc_pulse

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // Main sequence; writes keep reserved bits zero
    initial begin
        logic [3:0] tc;
        logic [1:0] ic;
        void'($urandom(32'h4F4D));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rc(8'h64, pw(0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0), "port reset");
        rc(8'h7C, 32'h0000_0000, "unmapped");
        att <= 1'b1;
        pins();
        wr(8'h64, 32'h0003_8184);
        rc(8'h64, pw(0, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0), "unpowered");
        // Power on; settle kept short here, real software waits the full time
        wr(8'h64, 32'h0000_1000);
        pins();
        rc(8'h64, pw(0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 1, 1), "attach");
        rc(8'h70, 32'h0000_0001, "event sts");
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(8'h74, 32'h0000_0003);
        @(negedge clk_sys);
        chk("irq raised", {31'h0, irq}, 32'h1);
        wr(8'h70, 32'h0000_0001);
        @(negedge clk_sys);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(8'h64, 32'h0000_1002);
        rc(8'h64, pw(0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1), "csc w1c");
        // Configured bit set last, toggled to see owner follow
        wr(8'h60, 32'h0000_0001);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1), "owner cfg");
        wr(8'h60, 32'h0000_0000);
        rc(8'h64, pw(0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0, 1), "owner uncfg");
        wr(8'h60, 32'h0000_0001);
        wr(8'h64, 32'h0000_1100);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 1, 0, 0, 0, 0, 1), "bus reset");
        chk("port ctl", {19'h0, ctl}, 32'h0000_1400);
        wr(8'h64, 32'h0000_1000);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1), "enabled");
        wr(8'h64, 32'h0000_1084);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 0, 1, 0, 1, 0, 1), "suspend");
        res <= 1'b1;
        pins();
        rc(8'h64, pw(0, 0, 0, 1, 0, 1, 0, 1, 1, 1, 0, 1), "resume k");
        chk("port ctl", {19'h0, ctl}, 32'h0000_1B00);
        rc(8'h70, 32'h0000_0002, "resume sts");
        res <= 1'b0;
        pins();
        wr(8'h64, 32'h0000_1004);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1), "resume end");
        wr(8'h70, 32'h0000_0002);
        wr(8'h64, 32'h0000_D004);
        rc(8'h64, pw(0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1), "no ind cap");
        ind <= 1'b1;
        // Every test select with a random indicator value
        for (int i = 0; i < 16; i++) begin
            tc = 4'(i);
            ic = 2'($urandom);
            wr(8'h64, {12'h000, tc, ic, 14'h1004});
            rc(8'h64, pw(tc, ic, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1), "test sel");
            chk("test_sel pin", {28'h0, ctl.test_sel}, {28'h0, tc});
            chk("test_mode pin", {31'h0, ctl.test_mode}, {31'h0, tc != 4'h0});
            chk("indicator pin", {30'h0, ctl.indicator}, {30'h0, ic});
        end
        // Lane 2 off: test select keeps its last value
        lanes = 4'hB;
        wr(8'h64, 32'h0000_1004);
        rc(8'h64, pw(4'hF, 0, 0, 1, 1, 0, 0, 0, 0, 1, 0, 1), "lane kept");
        lanes = 4'hF;
        wr(8'h64, 32'h0000_1004);
        hc_pulse();
        rc(8'h64, pw(0, 0, 1, 0, 1, 0, 0, 0, 0, 0, 0, 0), "hc reset");
        chk("port ctl", {19'h0, ctl}, 32'h0000_0080);
        wr(8'h64, 32'h0000_1000);
        pins();
        rc(8'h64, pw(0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 1, 1), "reconnect");
        att <= 1'b0;
        pins();
        rc(8'h64, pw(0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 1, 0), "detach");
        psw <= 1'b0;
        hc_pulse();
        rc(8'h64, pw(0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0), "fixed power");
        wr(8'h64, 32'h0000_0000);
        rc(8'h64, pw(0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0), "power stuck");
        print_verdict();
    end

    // Watchdog far beyond the few hundred cycles the run needs
    initial begin
        #80000;
        errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
